// ==== hdl/cau_pkg.sv ====
// Constants shared by the core address and stack unit.
// Assumes a 32-bit AHB-Lite register bus and 16-bit memories.
package cau_pkg;
  // ----------------------------------------
  // Reset values and stack index width
  // ----------------------------------------
  localparam logic [15:0] CAU_FETCH_RESET = 16'h8000;
  localparam logic [15:0] CAU_USER_START = 16'h0000;
  localparam int CAU_SIDX_W = 4;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CAU_OFF_FETCH = 8'h00;
  localparam logic [7:0] CAU_OFF_DP0 = 8'h04;
  localparam logic [7:0] CAU_OFF_DP1 = 8'h08;
  localparam logic [7:0] CAU_OFF_FBASE = 8'h0c;
  localparam logic [7:0] CAU_OFF_FDISP = 8'h10;
  localparam logic [7:0] CAU_OFF_DATA = 8'h14;
  localparam logic [7:0] CAU_OFF_CMD = 8'h18;
  localparam logic [7:0] CAU_OFF_STATUS = 8'h1c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CAU_CMD_SEL_LSB = 4;
  localparam int CAU_CMD_MODE_LSB = 6;
  localparam int CAU_CMD_BYTE = 8;
  localparam int CAU_ST_BOOT = 0;
  localparam int CAU_ST_INS = 1;
  localparam int CAU_ST_RUN = 2;
  localparam int CAU_ST_BUSY = 3;
  localparam int CAU_ST_SIDX_LSB = 8;
  // ----------------------------------------
  // Commands, pointer selects, step modes
  // ----------------------------------------
  localparam logic [3:0] CAU_OP_LOAD = 4'h1;
  localparam logic [3:0] CAU_OP_STORE = 4'h2;
  localparam logic [3:0] CAU_OP_PUSH = 4'h3;
  localparam logic [3:0] CAU_OP_POP = 4'h4;
  localparam logic [3:0] CAU_OP_POP_AND_CLEAR_SERVICE = 4'h5;
  localparam logic [3:0] CAU_OP_CALL = 4'h6;
  localparam logic [3:0] CAU_OP_RET = 4'h7;
  localparam logic [3:0] CAU_OP_INTERRUPT_RETURN = 4'h8;
  localparam logic [3:0] CAU_OP_INTV = 4'h9;
  localparam logic [1:0] CAU_SEL_DP0 = 2'h0;
  localparam logic [1:0] CAU_SEL_DP1 = 2'h1;
  localparam logic [1:0] CAU_SEL_FRAME = 2'h2;
  localparam logic [1:0] CAU_MODE_INC = 2'h1;
  localparam logic [1:0] CAU_MODE_DEC = 2'h2;
  typedef enum logic [0:0] {CAU_IDLE = 1'b0, CAU_LOADW = 1'b1} cau_state_t;
endpackage

// ==== hdl/cau_core.sv ====
// Fetch pointer, data pointers, frame pointer and hardware stack.
// Assumes single-cycle SRAM on the data port, same clock for all
// inputs except the test-port boot request pin.
// Notes on behaviour
// R1: Fetch pointer is 16 bits, linear space.
// R2: Written fetch pointer is fetched next cycle.
// R3: Fetch pointer advances by one per fetch.
// R4: Reset loads fetch pointer with 8000h.
// R5: Boot request bit resets to zero.
// R6: Test port sets boot request during reset.
// R7: Pointer source loads, pointer destination stores.
// R8: Two independent software-visible 16-bit data pointers.
// R9: Increment: after reads, before writes.
// R10: Decrement: after reads, before writes.
// R11: Frame address is base plus displacement.
// R12: Frame step: before store, after load.
// R13: Displacement carry never touches frame base.
// R14: Each memory access takes one clock.
// R15: Word or byte accesses supported.
// R16: Stack serves calls, returns, interrupts, push, pop.
// R17: Pop-and-clear-service pops and clears in-service.
// R18: Stack depth is two to index width.
// R19: Reset puts stack index at top entry.
// R20: Push increments index, then writes.
// R21: Pop reads entry, then decrements index.
// R22: Stack uninitialised and private to stack ops.
// R23: Stack index wraps silently.
`timescale 1ns/1ps
`default_nettype none
module cau_core
  import cau_pkg::*;
#(
  parameter int SIDX_W = cau_pkg::CAU_SIDX_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Device reset and test port
  input wire logic core_reset,
  input wire logic jtag_boot_set,
  // Program memory
  output logic [15:0] prog_addr,
  output logic prog_fetch,
  // Data memory
  output logic [15:0] dmem_addr,
  output logic dmem_rd,
  output logic dmem_wr,
  output logic [1:0] dmem_be,
  output logic [15:0] dmem_wdata,
  input wire logic [15:0] dmem_rdata
);
  import cau_pkg::*;

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  localparam int DEPTH = 2 ** SIDX_W; // R18

  typedef struct packed {
    cau_state_t state;
    logic [15:0] fetch_ptr;
    logic run;
    logic boot;
    logic interrupt_in_service_flag;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic [15:0] fbase;
    logic [15:0] fdisp;
    logic [15:0] data;
    logic [15:0] cmd;
    logic [SIDX_W-1:0] sidx;
    logic [1:0] p_sel;
    logic [1:0] p_mode;
    logic p_byte;
    logic p_lane;
    logic a_wr;
    logic a_rd;
    logic a_map;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic ready;
    logic [15:0] prog_addr;
    logic prog_fetch;
    logic [15:0] dm_addr;
    logic dm_rd;
    logic dm_wr;
    logic [1:0] dm_be;
    logic [15:0] dm_wdata;
    logic j1;
    logic j2;
  } cau_regs_t;

  cau_regs_t q;
  cau_regs_t n;

  // Uninitialised on purpose; only stack ops reach it
  logic [15:0] stack_mem [DEPTH]; // R22
  logic st_we;
  logic [SIDX_W-1:0] st_widx;
  logic [15:0] st_wdata;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] cau_step(input logic [15:0] v,
                                           input logic [1:0] m);
    logic [15:0] r;
    r = v;
    if (m == CAU_MODE_INC) begin
      r = 16'(v + 16'h0001); // R9
    end else if (m == CAU_MODE_DEC) begin
      r = 16'(v - 16'h0001); // R10
    end
    return r;
  endfunction

  // Byte pointers address words by dropping the lane bit
  function automatic logic [15:0] cau_word(input logic [15:0] a,
                                           input logic b);
    return b ? {1'b0, a[15:1]} : a; // R15
  endfunction

  function automatic logic [15:0] cau_frame(input logic [15:0] b,
                                            input logic [15:0] d);
    return 16'(b + d); // R11
  endfunction

  logic ahb_go;
  logic wr_ev;
  logic cmd_ev;
  logic [3:0] cmd_op;
  logic [1:0] cmd_sel;
  logic [1:0] cmd_mode;
  logic cmd_byte;
  logic branch_ev;
  logic fp_wr;

  assign ahb_go = hsel && hready && htrans[1];
  assign wr_ev = q.a_wr && q.a_map;
  assign fp_wr = wr_ev && (q.a_addr == CAU_OFF_FETCH);
  assign cmd_ev = wr_ev && (q.a_addr == CAU_OFF_CMD) &&
                  (q.state == CAU_IDLE) && !core_reset;
  assign cmd_op = hwdata[3:0];
  assign cmd_sel = hwdata[CAU_CMD_SEL_LSB +: 2];
  assign cmd_mode = hwdata[CAU_CMD_MODE_LSB +: 2];
  assign cmd_byte = hwdata[CAU_CMD_BYTE];
  assign branch_ev = cmd_ev && (cmd_op == CAU_OP_CALL ||
                     cmd_op == CAU_OP_RET || cmd_op == CAU_OP_INTERRUPT_RETURN ||
                     cmd_op == CAU_OP_INTV);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [15:0] nxt;
    logic [15:0] ptr;
    logic [15:0] adr;
    logic [SIDX_W-1:0] up;
    nxt = q.fetch_ptr;
    ptr = 16'h0000;
    adr = 16'h0000;
    up = SIDX_W'(q.sidx + 1'b1); // R23
    n = q;
    st_we = 1'b0;
    st_widx = up;
    st_wdata = q.data;
    n.j1 = jtag_boot_set;
    n.j2 = q.j1;
    n.ready = 1'b1;
    n.prog_fetch = 1'b0;
    n.dm_rd = 1'b0;
    n.dm_wr = 1'b0;
    n.dm_be = 2'b00;
    // Bus address phase
    n.a_wr = ahb_go && hwrite;
    n.a_rd = ahb_go && !hwrite;
    n.a_map = (haddr[31:5] == '0);
    n.a_addr = haddr[7:0];
    // Bus data phase writes
    if (wr_ev) begin
      case (q.a_addr)
        CAU_OFF_FETCH: nxt = hwdata[15:0]; // R2
        CAU_OFF_DP0: n.dp0 = hwdata[15:0]; // R8
        CAU_OFF_DP1: n.dp1 = hwdata[15:0]; // R8
        CAU_OFF_FBASE: n.fbase = hwdata[15:0];
        CAU_OFF_FDISP: n.fdisp = hwdata[15:0];
        CAU_OFF_DATA: n.data = hwdata[15:0];
        CAU_OFF_CMD: n.cmd = hwdata[15:0];
        CAU_OFF_STATUS: begin
          n.boot = hwdata[CAU_ST_BOOT];
          n.run = hwdata[CAU_ST_RUN];
        end
        default: n.data = q.data;
      endcase
    end
    // Completion of a load, post step of the pointer
    if (q.state == CAU_LOADW) begin
      n.state = CAU_IDLE;
      if (q.p_byte) begin
        n.data = {8'h00, q.p_lane ? dmem_rdata[15:8] :
                  dmem_rdata[7:0]}; // R15
      end else begin
        n.data = dmem_rdata; // R14
      end
      case (q.p_sel)
        CAU_SEL_DP0: n.dp0 = cau_step(q.dp0, q.p_mode); // R9
        CAU_SEL_DP1: n.dp1 = cau_step(q.dp1, q.p_mode); // R10
        default: n.fdisp = cau_step(q.fdisp, q.p_mode); // R12
      endcase
    end
    // Commands
    if (cmd_ev) begin
      case (cmd_sel)
        CAU_SEL_DP0: ptr = q.dp0;
        CAU_SEL_DP1: ptr = q.dp1;
        default: ptr = cau_frame(q.fbase, q.fdisp); // R11
      endcase
      case (cmd_op)
        CAU_OP_LOAD: begin
          n.state = CAU_LOADW; // R7
          n.dm_rd = 1'b1;
          n.dm_be = 2'b11;
          n.dm_addr = cau_word(ptr, cmd_byte);
          n.p_sel = cmd_sel;
          n.p_mode = cmd_mode;
          n.p_byte = cmd_byte;
          n.p_lane = ptr[0];
        end
        CAU_OP_STORE: begin
          // Pre step; base untouched, carry dropped
          case (cmd_sel)
            CAU_SEL_DP0: begin
              adr = cau_step(q.dp0, cmd_mode); // R9
              n.dp0 = adr;
            end
            CAU_SEL_DP1: begin
              adr = cau_step(q.dp1, cmd_mode); // R10
              n.dp1 = adr;
            end
            default: begin
              n.fdisp = cau_step(q.fdisp, cmd_mode); // R12
              adr = cau_frame(q.fbase, n.fdisp); // R13
            end
          endcase
          n.dm_wr = 1'b1; // R7
          n.dm_addr = cau_word(adr, cmd_byte);
          if (cmd_byte) begin
            n.dm_be = adr[0] ? 2'b10 : 2'b01; // R15
            n.dm_wdata = {q.data[7:0], q.data[7:0]};
          end else begin
            n.dm_be = 2'b11;
            n.dm_wdata = q.data;
          end
        end
        CAU_OP_PUSH: begin
          st_we = 1'b1; // R20
          n.sidx = up;
        end
        CAU_OP_CALL, CAU_OP_INTV: begin
          st_we = 1'b1; // R16
          st_wdata = q.fetch_ptr;
          n.sidx = up;
          nxt = q.data;
          if (cmd_op == CAU_OP_INTV) begin
            n.interrupt_in_service_flag = 1'b1;
          end
        end
        CAU_OP_POP, CAU_OP_POP_AND_CLEAR_SERVICE: begin
          n.data = stack_mem[q.sidx]; // R21
          n.sidx = SIDX_W'(q.sidx - 1'b1); // R23
          if (cmd_op == CAU_OP_POP_AND_CLEAR_SERVICE) begin
            n.interrupt_in_service_flag = 1'b0; // R17
          end
        end
        CAU_OP_RET, CAU_OP_INTERRUPT_RETURN: begin
          nxt = stack_mem[q.sidx]; // R16
          n.sidx = SIDX_W'(q.sidx - 1'b1); // R21
        end
        default: n.cmd = hwdata[15:0];
      endcase
    end
    // Fetch: while run is set and device reset is low, pointer names the word after the fetched one
    if (q.run) begin
      n.prog_addr = nxt; // R1
      n.prog_fetch = 1'b1;
      n.fetch_ptr = 16'(nxt + 16'h0001); // R3
    end else begin
      n.fetch_ptr = nxt;
    end
    // Device reset holds the fetch and stack logic
    if (core_reset) begin
      n.fetch_ptr = CAU_FETCH_RESET; // R4
      n.prog_fetch = 1'b0;
      n.sidx = {SIDX_W{1'b1}}; // R19
      n.interrupt_in_service_flag = 1'b0;
      n.state = CAU_IDLE;
      n.dm_rd = 1'b0;
      if (q.j2) begin
        n.boot = 1'b1; // R6
      end
    end
    // Read data shows the state as it stands after this edge
    if (ahb_go && !hwrite) begin
      n.hrdata = 32'h0000_0000;
      if (haddr[31:5] == '0) begin
        case (haddr[7:0])
          CAU_OFF_FETCH: n.hrdata[15:0] = n.fetch_ptr;
          CAU_OFF_DP0: n.hrdata[15:0] = n.dp0;
          CAU_OFF_DP1: n.hrdata[15:0] = n.dp1;
          CAU_OFF_FBASE: n.hrdata[15:0] = n.fbase;
          CAU_OFF_FDISP: n.hrdata[15:0] = n.fdisp;
          CAU_OFF_DATA: n.hrdata[15:0] = n.data;
          CAU_OFF_CMD: n.hrdata[15:0] = n.cmd;
          CAU_OFF_STATUS: begin
            n.hrdata[CAU_ST_BOOT] = n.boot; // R5
            n.hrdata[CAU_ST_INS] = n.interrupt_in_service_flag;
            n.hrdata[CAU_ST_RUN] = n.run;
            n.hrdata[CAU_ST_BUSY] = (n.state == CAU_LOADW);
            n.hrdata[CAU_ST_SIDX_LSB +: SIDX_W] = n.sidx;
          end
          default: n.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.state <= CAU_IDLE;
      q.fetch_ptr <= CAU_FETCH_RESET; // R4
      q.run <= 1'b1;
      q.boot <= 1'b0; // R5
      q.sidx <= {SIDX_W{1'b1}}; // R19
      q.ready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge hclk) begin
    if (st_we) begin
      stack_mem[st_widx] <= st_wdata; // R20
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign prog_addr = q.prog_addr;
  assign prog_fetch = q.prog_fetch;
  assign dmem_addr = q.dm_addr;
  assign dmem_rd = q.dm_rd;
  assign dmem_wr = q.dm_wr;
  assign dmem_be = q.dm_be;
  assign dmem_wdata = q.dm_wdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  fetch_load_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    fp_wr && q.run && !core_reset |=>
    prog_fetch && prog_addr == $past(hwdata[15:0]))
    else $error("fetch not from written address");

  fetch_inc_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    q.run && !core_reset && !fp_wr && !branch_ev |=>
    q.fetch_ptr == 16'($past(q.fetch_ptr) + 16'h0001))
    else $error("fetch pointer did not advance by one");

  reset_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    core_reset |=> q.fetch_ptr == CAU_FETCH_RESET && !prog_fetch &&
    q.sidx == {SIDX_W{1'b1}})
    else $error("device reset values wrong");

  boot_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    core_reset && q.j2 |=> q.boot)
    else $error("test port boot request lost");

  dm_single_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    dmem_rd |-> q.state == CAU_LOADW ##1
    (!dmem_rd && q.state == CAU_IDLE))
    else $error("data read longer than one cycle");

  frame_sum_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    dmem_rd && q.p_sel == CAU_SEL_FRAME |->
    dmem_addr == cau_word(16'(q.fbase + q.fdisp), q.p_byte))
    else $error("frame address not base plus displacement");

  base_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    cmd_ev && cmd_sel == CAU_SEL_FRAME |=> $stable(q.fbase))
    else $error("frame base changed by step");

  post_step_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    q.state == CAU_LOADW && q.p_sel == CAU_SEL_DP0 &&
    q.p_mode == CAU_MODE_INC && !core_reset |=>
    q.dp0 == 16'($past(q.dp0) + 16'h0001))
    else $error("data pointer post increment wrong");

  push_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // R20
    cmd_ev && cmd_op == CAU_OP_PUSH |=>
    q.sidx == SIDX_W'($past(q.sidx) + 1'b1) &&
    stack_mem[q.sidx] == $past(q.data))
    else $error("push order wrong");

  pop_order_a: assert property (@(posedge hclk) disable iff (!hresetn) // R21
    cmd_ev && cmd_op == CAU_OP_POP |=>
    q.data == $past(stack_mem[q.sidx]) &&
    q.sidx == SIDX_W'($past(q.sidx) - 1'b1))
    else $error("pop order wrong");

  pop_and_clear_service_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    cmd_ev && cmd_op == CAU_OP_POP_AND_CLEAR_SERVICE |=> !q.interrupt_in_service_flag)
    else $error("service flag not cleared");

endmodule
`default_nettype wire

// ==== bench/cau_mem_model.sv ====
// Data memory beside the address and stack unit, 1k words deep.
// Assumes the unit's word address and byte lanes, same clock.
`timescale 1ns/1ps
`default_nettype none
module cau_mem_model (
  // Clock
  input wire logic hclk,
  // Data memory port
  input wire logic [15:0] dmem_addr,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic [1:0] dmem_be,
  input wire logic [15:0] dmem_wdata,
  output logic [15:0] dmem_rdata
);
  logic [15:0] mem [0:1023];
  // ----------------------------------------
  // Known pattern so the bench can predict loads
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'(i) ^ 16'h5a5a;
    end
  end
  // Idle bus shows the inverse, never a stale match
  assign dmem_rdata = dmem_rd ? mem[dmem_addr[9:0]] :
                      ~mem[dmem_addr[9:0]];
  // One-cycle write, lanes independent
  always @(posedge hclk) begin
    if (dmem_wr) begin
      if (dmem_be[0]) mem[dmem_addr[9:0]][7:0] = dmem_wdata[7:0];
      if (dmem_be[1]) mem[dmem_addr[9:0]][15:8] = dmem_wdata[15:8];
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the address and stack unit.
// Assumes the unit's AHB-Lite map and the data memory model.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cau_pkg::*;
  localparam int SW = 4;
  localparam logic [15:0] TOP = 16'((1 << SW) - 1);
  logic hclk, hresetn, hsel, hwrite, core_reset, jtag_boot_set;
  logic hreadyout, hresp, prog_fetch, dmem_rd, dmem_wr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, dmem_be;
  logic [2:0] hsize;
  logic [15:0] prog_addr, dmem_addr, dmem_wdata, dmem_rdata, rd_addr, v;
  int miscompares, comparisons, rd_cnt;
  // ----------------------------------------
  // Clock, memory watch, instances
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (dmem_rd === 1'b1) begin
      rd_cnt++;
      rd_addr = dmem_addr;
    end
  end
  cau_core #(.SIDX_W(SW)) u_cau_core (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_reset(core_reset),
    .jtag_boot_set(jtag_boot_set), .prog_addr(prog_addr),
    .prog_fetch(prog_fetch), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_be(dmem_be), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata));
  cau_mem_model u_cau_mem_model (.hclk(hclk), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_be(dmem_be),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Address phase held until hready, then data phase until hready
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata[15:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [15:0] e);
    xfer(1'b0, a, 16'h0);
    chk(n, {hrdata[31:16], v}, {16'h0, e});
  endtask
  task automatic op(input logic [3:0] c, input logic [1:0] s,
                    input logic [1:0] m, input logic b);
    wr(CAU_OFF_CMD, {7'h0, b, m, s, c});
  endtask
  function automatic logic [15:0] st(input logic [15:0] i,
                                     input logic [7:0] lo);
    return (i << 8) | {8'h0, lo};
  endfunction
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog: the run needs well under 1000 cycles
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge hclk);
    miscompares++;
    finish_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    core_reset = 1'b0;
    jtag_boot_set = 1'b0;
    miscompares = 0;
    comparisons = 0;
    rd_cnt = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    chk("prog_addr", prog_addr, 16'h8000);
    chk("prog_fetch", prog_fetch, 1'b1);
    @(posedge hclk);
    #1;
    chk("prog_addr", prog_addr, 16'h8001);
    @(posedge hclk);
    rdc("status", CAU_OFF_STATUS, st(TOP, 8'h04));
    chk("hresp", hresp, 1'b0);
    wr(CAU_OFF_FETCH, 16'h1234);
    #1;
    chk("prog_addr", prog_addr, 16'h1234);
    @(posedge hclk);
    #1;
    chk("prog_addr", prog_addr, 16'h1235);
    @(posedge hclk);
    $display("test fetch done");
    wr(CAU_OFF_DP0, 16'h0010);
    wr(CAU_OFF_DP1, 16'h0020);
    rdc("dp0", CAU_OFF_DP0, 16'h0010);
    rdc("dp1", CAU_OFF_DP1, 16'h0020);
    op(CAU_OP_LOAD, CAU_SEL_DP0, CAU_MODE_INC, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h0010 ^ 16'h5a5a);
    chk("rd_addr", rd_addr, 16'h0010);
    chk("rd_cnt", rd_cnt, 1);
    rdc("dp0", CAU_OFF_DP0, 16'h0011);
    wr(CAU_OFF_DATA, 16'hbeef);
    op(CAU_OP_STORE, CAU_SEL_DP1, CAU_MODE_DEC, 1'b0);
    rdc("dp1", CAU_OFF_DP1, 16'h001f);
    chk("mem1f", u_cau_mem_model.mem[16'h1f], 16'hbeef);
    $display("test pointer done");
    wr(CAU_OFF_FBASE, 16'h0100);
    wr(CAU_OFF_FDISP, 16'hffff);
    wr(CAU_OFF_DATA, 16'h1234);
    op(CAU_OP_STORE, CAU_SEL_FRAME, CAU_MODE_INC, 1'b0);
    rdc("fdisp", CAU_OFF_FDISP, 16'h0000);
    rdc("fbase", CAU_OFF_FBASE, 16'h0100);
    chk("mem100", u_cau_mem_model.mem[16'h100], 16'h1234);
    op(CAU_OP_LOAD, CAU_SEL_FRAME, CAU_MODE_DEC, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h1234);
    rdc("fdisp", CAU_OFF_FDISP, 16'hffff);
    rdc("fbase", CAU_OFF_FBASE, 16'h0100);
    $display("test frame done");
    wr(CAU_OFF_DP0, 16'h0021);
    wr(CAU_OFF_DATA, 16'h0077);
    op(CAU_OP_STORE, CAU_SEL_DP0, 2'h0, 1'b1);
    wr(CAU_OFF_DP0, 16'h0020);
    chk("mem10", u_cau_mem_model.mem[16'h10], 16'h774a);
    op(CAU_OP_LOAD, CAU_SEL_DP0, 2'h0, 1'b1);
    rdc("data", CAU_OFF_DATA, 16'h004a);
    wr(CAU_OFF_DP0, 16'h0021);
    op(CAU_OP_LOAD, CAU_SEL_DP0, 2'h0, 1'b1);
    rdc("data", CAU_OFF_DATA, 16'h0077);
    $display("test byte done");
    // Fetch stopped so the pushed return address is known
    wr(CAU_OFF_STATUS, 16'h0000);
    wr(CAU_OFF_FETCH, 16'h0100);
    for (int i = 0; i <= int'(TOP) + 1; i++) begin
      wr(CAU_OFF_DATA, 16'h0a00 + 16'(i));
      op(CAU_OP_PUSH, 2'h0, 2'h0, 1'b0);
    end
    rdc("status", CAU_OFF_STATUS, st(16'h0, 8'h00));
    op(CAU_OP_POP, 2'h0, 2'h0, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h0a00 + TOP + 16'h1);
    op(CAU_OP_POP, 2'h0, 2'h0, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h0a00 + TOP);
    rdc("status", CAU_OFF_STATUS, st(TOP - 16'h1, 8'h00));
    wr(CAU_OFF_DATA, 16'h0300);
    op(CAU_OP_CALL, 2'h0, 2'h0, 1'b0);
    rdc("fetch", CAU_OFF_FETCH, 16'h0300);
    op(CAU_OP_POP, 2'h0, 2'h0, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h0100);
    wr(CAU_OFF_DATA, 16'h0400);
    op(CAU_OP_INTV, 2'h0, 2'h0, 1'b0);
    rdc("fetch", CAU_OFF_FETCH, 16'h0400);
    rdc("status", CAU_OFF_STATUS, st(TOP, 8'h02));
    op(CAU_OP_INTERRUPT_RETURN, 2'h0, 2'h0, 1'b0);
    rdc("fetch", CAU_OFF_FETCH, 16'h0300);
    rdc("status", CAU_OFF_STATUS, st(TOP - 16'h1, 8'h02));
    op(CAU_OP_INTV, 2'h0, 2'h0, 1'b0);
    op(CAU_OP_POP_AND_CLEAR_SERVICE, 2'h0, 2'h0, 1'b0);
    rdc("data", CAU_OFF_DATA, 16'h0300);
    rdc("status", CAU_OFF_STATUS, st(TOP - 16'h1, 8'h00));
    wr(CAU_OFF_DATA, 16'h0600);
    op(CAU_OP_CALL, 2'h0, 2'h0, 1'b0);
    op(CAU_OP_RET, 2'h0, 2'h0, 1'b0);
    // Last vectoring left the pointer at the vector, so that is pushed
    rdc("fetch", CAU_OFF_FETCH, 16'h0400);
    $display("test stack done");
    wr(CAU_OFF_STATUS, 16'h0004);
    core_reset <= 1'b1;
    jtag_boot_set <= 1'b1;
    repeat (6) @(posedge hclk);
    #1;
    chk("prog_fetch", prog_fetch, 1'b0);
    @(posedge hclk);
    core_reset <= 1'b0;
    jtag_boot_set <= 1'b0;
    @(posedge hclk);
    #1;
    chk("prog_addr", prog_addr, 16'h8000);
    @(posedge hclk);
    rdc("status", CAU_OFF_STATUS, st(TOP, 8'h05));
    wr(CAU_OFF_STATUS, 16'h0004);
    rdc("status", CAU_OFF_STATUS, st(TOP, 8'h04));
    $display("test boot done");
    finish_test;
  end
endmodule
`default_nettype wire
